// ---- design/clk_gen_pkg.sv ----
// Constants, register map and encodings for the clock generation block.
// Assumes a single 100 MHz control clock; oscillator levels arrive synchronous to it.
package clk_gen_pkg;

  localparam int CLK_PERIOD_NS  = 10;
  localparam int PLL_SETTLE_NS  = 100000;
  localparam int SYSOSC_WAKE_NS = 500000;
  localparam int PLL_LOCK_CYCLES  = (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYSOSC_RDY_CYCLES = (SYSOSC_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int NUM_SRC  = 5;

  // Register byte addresses
  localparam logic [7:0] PLL_CTRL_ADDR = 8'h00;
  localparam logic [7:0] MAIN_SEL_ADDR = 8'h04;
  localparam logic [7:0] CLOCK_OUTPUT_PIN_ADDR   = 8'h08;
  localparam logic [7:0] OSC_CTRL_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_ADDR   = 8'h10;

  // Field positions
  localparam int MSEL_LSB   = 0;
  localparam int MSEL_W     = 5;
  localparam int PSEL_LSB   = 5;
  localparam int PSEL_W     = 2;
  localparam int PLL_PD_BIT = 7;
  localparam int PLL_SRC_BIT = 8;
  localparam int SEL_LSB    = 0;
  localparam int MAIN_SEL_W = 3;
  localparam int CO_SEL_W   = 2;
  localparam int CO_EN_BIT  = 2;
  localparam int SYSOSC_EN_BIT = 0;
  localparam int WDF_LSB    = 1;
  localparam int WDF_W      = 4;
  localparam int WDT_SEL_BIT = 5;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_SOSC_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_ACT_LSB  = 3;

  // Reset values
  localparam logic [MSEL_W-1:0] MSEL_RST  = 5'h00;
  localparam logic [PSEL_W-1:0] PSEL_RST  = 2'h0;
  localparam logic [WDF_W-1:0]  WDF_RST   = 4'h0;

  // RTC dividers on 32 kHz edges
  localparam int RTC_CNT_W  = 15;
  localparam int RTC_KHZ_BIT = 4;
  localparam int RTC_HZ_BIT  = 14;

  typedef enum logic [2:0] {
    MAIN_IRC    = 3'b000,
    MAIN_PLL_IN = 3'b001,
    MAIN_WDOSC  = 3'b010,
    MAIN_PLL    = 3'b011,
    MAIN_RTC32K = 3'b100
  } main_src_t;

  typedef enum logic [1:0] {
    CO_IRC    = 2'b00,
    CO_SYSOSC = 2'b01,
    CO_WDOSC  = 2'b10,
    CO_MAIN   = 2'b11
  } clock_output_pin_src_t;

endpackage

// ---- design/clk_sw_if.sv ----
// Bundle between the control top and the glitch-free main clock switch.
// Assumes both ends share mclk.
`timescale 1ns/10ps
interface clk_sw_if;
  import clk_gen_pkg::*;
  logic [NUM_SRC-1:0] src;
  logic [NUM_SRC-1:0] sel;
  logic [NUM_SRC-1:0] act;
  logic               busy;
  logic               clk_out;
  modport ctrl (output src, output sel, input act, input busy, input clk_out);
  modport sw   (input src, input sel, output act, output busy, output clk_out);
endinterface

// ---- design/clk_switch.sv ----
// Glitch-free clock selector over sampled clock levels.
// Assumes sources are levels synchronous to mclk and sel is one-hot.
`timescale 1ns/10ps
module clk_switch
  import clk_gen_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic ce,
  clk_sw_if.sw      bus
);

  logic [NUM_SRC-1:0] en_reg;
  logic               out_reg;

  // Enables change only while the source is low, so no pulse is ever cut
  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          en_reg[i] <= (i == 0);
        end else if (ce && !bus.src[i]) begin
          if (en_reg[i] && !bus.sel[i]) begin
            en_reg[i] <= 1'b0;
          end else if (!en_reg[i] && bus.sel[i] && ((en_reg & ~(NUM_SRC'(1) << i)) == '0)) begin
            en_reg[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_reg <= 1'b0;
    end else if (ce) begin
      out_reg <= |(en_reg & bus.src);
    end
  end

  assign bus.act     = en_reg;
  assign bus.busy    = (en_reg != bus.sel);
  assign bus.clk_out = out_reg;

endmodule

// ---- design/clk_gen_top.sv ----
// Clock generation and selection: PLL model, main clock switch, clock output, RTC dividers.
// Assumes oscillator levels are synchronous to mclk and software keeps PLL limits.
//
// Overview of operation
// - Run from internal RC after any reset
// - PLL powered off and bypassed after reset
// - PLL multiplier accepts integers 1 to 32
// - Post-divider offers ratios 2, 4, 8, 16
// - PLL output always has 50 % duty; while powered down, pll_clk passes the reference through with its own duty
// - Clock output muxes RC, sysosc, watchdog, main
// - System oscillator usable about 500 us after enable
// - RTC oscillator gives 1 Hz, 1 kHz, 32 kHz
// - Watchdog oscillator drives CPU, timer or output
// - Internal RC clocks watchdog timer or PLL
// - System oscillator feeds CPU directly or via PLL
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module clk_gen_top
  import clk_gen_pkg::*;
#(
  parameter int unsigned PLL_LOCK_CYC   = PLL_LOCK_CYCLES,
  parameter int unsigned SYSOSC_RDY_CYC = SYSOSC_RDY_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              internal_rc_osc,
  input  wire logic              sysosc_in,
  input  wire logic              wdosc_in,
  input  wire logic              rtc32k_in,
  output logic                   sysosc_en,
  output logic      [WDF_W-1:0]  wdosc_freq,
  output logic                   pll_pd,
  output logic                   pll_clk,
  output logic                   main_clk,
  output logic                   clock_output_pin,
  output logic                   watchdog_timer_clk,
  output logic                   rtc_1hz,
  output logic                   rtc_1khz,
  output logic                   rtc_32k
);

  clk_sw_if sw_bus ();

  // Counters sized to their terminal counts
  localparam int LOCK_CNT_W = $clog2(PLL_LOCK_CYC + 1);
  localparam int SOSC_CNT_W = $clog2(SYSOSC_RDY_CYC + 1);

  // Control registers
  logic [MSEL_W-1:0]     msel_reg;
  logic [PSEL_W-1:0]     psel_reg;
  logic                  pll_pd_reg;
  logic                  pll_src_reg;
  main_src_t             main_sel_reg;
  clock_output_pin_src_t           co_sel_reg;
  logic                  co_en_reg;
  logic                  sysosc_en_reg;
  logic [WDF_W-1:0]      wdf_reg;
  logic                  wdt_sel_reg;

  // Status and datapath state
  logic [LOCK_CNT_W-1:0] lock_cnt_reg;
  logic                  lock_reg;
  logic [SOSC_CNT_W-1:0] sosc_cnt_reg;
  logic                  sosc_rdy_reg;
  logic [3:0]            div_cnt_reg;
  logic                  pll_out_reg;
  logic                  co_reg;
  logic                  wdt_reg;
  logic                  rtc32_prev_reg;
  logic                  rtc_arm_reg;
  logic [RTC_CNT_W-1:0]  rtc_cnt_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic [DATA_W-1:0]     rdata_next;
  logic [DATA_W-1:0]     status_word;

  logic                  wr_pll;
  logic                  wr_main;
  logic                  wr_co;
  logic                  wr_osc;
  logic                  pll_in;
  logic [3:0]            half_cnt;
  logic [NUM_SRC-1:0]    sel_onehot;

  // Strobes count only while the clock enable runs
  assign wr_pll  = ce && wr_stb && (addr == PLL_CTRL_ADDR);
  assign wr_main = ce && wr_stb && (addr == MAIN_SEL_ADDR);
  assign wr_co   = ce && wr_stb && (addr == CLOCK_OUTPUT_PIN_ADDR);
  assign wr_osc  = ce && wr_stb && (addr == OSC_CTRL_ADDR);

  // PLL configuration; powered down and bypassed from reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      msel_reg    <= MSEL_RST;
      psel_reg    <= PSEL_RST;
      pll_pd_reg  <= 1'b1;
      pll_src_reg <= 1'b0;
    end else if (wr_pll) begin
      msel_reg    <= wdata[MSEL_LSB +: MSEL_W];
      psel_reg    <= wdata[PSEL_LSB +: PSEL_W];
      pll_pd_reg  <= wdata[PLL_PD_BIT];
      pll_src_reg <= wdata[PLL_SRC_BIT];
    end
  end

  // Main clock selection; internal RC after any reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      main_sel_reg <= MAIN_IRC;
    end else if (wr_main) begin
      // Unknown codes keep the current selection
      case (wdata[SEL_LSB +: MAIN_SEL_W])
        MAIN_IRC:    main_sel_reg <= MAIN_IRC;
        MAIN_PLL_IN: main_sel_reg <= MAIN_PLL_IN;
        MAIN_WDOSC:  main_sel_reg <= MAIN_WDOSC;
        MAIN_PLL:    main_sel_reg <= MAIN_PLL;
        MAIN_RTC32K: main_sel_reg <= MAIN_RTC32K;
        default:     main_sel_reg <= main_sel_reg;
      endcase
    end
  end

  // Clock output selection
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      co_sel_reg <= CO_IRC;
      co_en_reg  <= 1'b0;
    end else if (wr_co) begin
      co_sel_reg <= clock_output_pin_src_t'(wdata[SEL_LSB +: CO_SEL_W]);
      co_en_reg  <= wdata[CO_EN_BIT];
    end
  end

  // Oscillator controls
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sysosc_en_reg <= 1'b0;
      wdf_reg       <= WDF_RST;
      wdt_sel_reg   <= 1'b0;
    end else if (wr_osc) begin
      sysosc_en_reg <= wdata[SYSOSC_EN_BIT];
      wdf_reg       <= wdata[WDF_LSB +: WDF_W];
      wdt_sel_reg   <= wdata[WDT_SEL_BIT];
    end
  end

  // Lock timer restarts on any reconfiguration; status only, selection is not gated
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lock_cnt_reg <= '0;
      lock_reg     <= 1'b0;
    end else if (ce) begin
      if (pll_pd_reg || wr_pll) begin
        lock_cnt_reg <= '0;
        lock_reg     <= 1'b0;
      end else if (lock_cnt_reg >= LOCK_CNT_W'(PLL_LOCK_CYC - 1)) begin
        lock_reg     <= 1'b1;
      end else begin
        lock_cnt_reg <= lock_cnt_reg + LOCK_CNT_W'(1);
      end
    end
  end

  // System oscillator start-up wait
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sosc_cnt_reg <= '0;
      sosc_rdy_reg <= 1'b0;
    end else if (ce) begin
      if (!sysosc_en_reg) begin
        sosc_cnt_reg <= '0;
        sosc_rdy_reg <= 1'b0;
      end else if (sosc_cnt_reg >= SOSC_CNT_W'(SYSOSC_RDY_CYC - 1)) begin
        sosc_rdy_reg <= 1'b1;
      end else begin
        sosc_cnt_reg <= sosc_cnt_reg + SOSC_CNT_W'(1);
      end
    end
  end

  // PLL reference: internal RC or system oscillator
  // Reference change is not glitch-guarded; make it while powered down
  assign pll_in = pll_src_reg ? sysosc_in : internal_rc_osc;

  // Post-divider half period is ratio/2, so duty is exactly half
  assign half_cnt = 4'h1 << psel_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg <= '0;
      pll_out_reg <= 1'b0;
    end else if (ce) begin
      if (pll_pd_reg) begin
        div_cnt_reg <= '0;
        pll_out_reg <= pll_in;
      end else if (div_cnt_reg >= half_cnt - 4'h1) begin
        div_cnt_reg <= '0;
        pll_out_reg <= ~pll_out_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 4'h1;
      end
    end
  end

  // One-hot request into the glitch-free switch
  always_comb begin
    sel_onehot = '0;
    case (main_sel_reg)
      MAIN_IRC:    sel_onehot[MAIN_IRC] = 1'b1;
      MAIN_PLL_IN: sel_onehot[MAIN_PLL_IN] = 1'b1;
      MAIN_WDOSC:  sel_onehot[MAIN_WDOSC] = 1'b1;
      MAIN_PLL:    sel_onehot[MAIN_PLL] = 1'b1;
      MAIN_RTC32K: sel_onehot[MAIN_RTC32K] = 1'b1;
      default:     sel_onehot[MAIN_IRC] = 1'b1;
    endcase
  end

  assign sw_bus.src[MAIN_IRC]    = internal_rc_osc;
  assign sw_bus.src[MAIN_PLL_IN] = pll_in;
  assign sw_bus.src[MAIN_WDOSC]  = wdosc_in;
  assign sw_bus.src[MAIN_PLL]    = pll_out_reg;
  assign sw_bus.src[MAIN_RTC32K] = rtc32k_in;
  assign sw_bus.sel              = sel_onehot;

  clk_switch u_switch (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ce    (ce),
    .bus   (sw_bus.sw)
  );

  // Clock output pin mux; idles low when disabled
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      co_reg <= 1'b0;
    end else if (ce) begin
      if (!co_en_reg) begin
        co_reg <= 1'b0;
      end else begin
        case (co_sel_reg)
          CO_IRC:    co_reg <= internal_rc_osc;
          CO_SYSOSC: co_reg <= sysosc_in;
          CO_WDOSC:  co_reg <= wdosc_in;
          CO_MAIN:   co_reg <= sw_bus.clk_out;
          default:   co_reg <= 1'b0;
        endcase
      end
    end
  end

  // Watchdog timer clock source
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_reg <= 1'b0;
    end else if (ce) begin
      wdt_reg <= wdt_sel_reg ? wdosc_in : internal_rc_osc;
    end
  end

  // RTC divisions from 32 kHz edges: /32 gives 1 kHz, /32768 gives 1 Hz
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rtc32_prev_reg <= 1'b0;
      rtc_arm_reg    <= 1'b0;
      rtc_cnt_reg    <= '0;
    end else if (ce) begin
      rtc32_prev_reg <= rtc32k_in;
      rtc_arm_reg    <= 1'b1;
      // A pin already high at release is not a rising edge
      if (rtc_arm_reg && rtc32k_in && !rtc32_prev_reg) begin
        rtc_cnt_reg <= rtc_cnt_reg + 15'h1;
      end
    end
  end

  // Status word kept apart so the read mux stays a plain select
  always_comb begin
    status_word                        = '0;
    status_word[ST_LOCK_BIT]           = lock_reg;
    status_word[ST_SOSC_BIT]           = sosc_rdy_reg;
    status_word[ST_BUSY_BIT]           = sw_bus.busy;
    status_word[ST_ACT_LSB +: NUM_SRC] = sw_bus.act;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = '0;
    case (addr)
      PLL_CTRL_ADDR: begin
        rdata_next[MSEL_LSB +: MSEL_W] = msel_reg;
        rdata_next[PSEL_LSB +: PSEL_W] = psel_reg;
        rdata_next[PLL_PD_BIT]         = pll_pd_reg;
        rdata_next[PLL_SRC_BIT]        = pll_src_reg;
      end
      MAIN_SEL_ADDR: rdata_next[SEL_LSB +: MAIN_SEL_W] = main_sel_reg;
      CLOCK_OUTPUT_PIN_ADDR: begin
        rdata_next[SEL_LSB +: CO_SEL_W] = co_sel_reg;
        rdata_next[CO_EN_BIT]           = co_en_reg;
      end
      OSC_CTRL_ADDR: begin
        rdata_next[SYSOSC_EN_BIT]    = sysosc_en_reg;
        rdata_next[WDF_LSB +: WDF_W] = wdf_reg;
        rdata_next[WDT_SEL_BIT]      = wdt_sel_reg;
      end
      STATUS_ADDR:   rdata_next = status_word;
      default: rdata_next = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  // Zero outside that cycle keeps a stale word off the bus
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= rd_stb ? rdata_next : '0;
    end
  end

  assign rdata              = rdata_reg;
  assign sysosc_en          = sysosc_en_reg;
  assign wdosc_freq         = wdf_reg;
  assign pll_pd             = pll_pd_reg;
  assign pll_clk            = pll_out_reg;
  assign main_clk           = sw_bus.clk_out;
  assign clock_output_pin   = co_reg;
  assign watchdog_timer_clk = wdt_reg;
  assign rtc_1khz           = rtc_cnt_reg[RTC_KHZ_BIT];
  assign rtc_1hz            = rtc_cnt_reg[RTC_HZ_BIT];
  assign rtc_32k            = rtc32_prev_reg;

endmodule

// ---- tb/clk_gen_properties.sv ----
// Port-level checks for the clock generation top.
// Assumes it is bound into clk_gen_top and shares its mclk and rst_b.
`timescale 1ns/10ps
module clk_gen_properties
  import clk_gen_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr_stb,
  input wire logic              rd_stb,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              internal_rc_osc,
  input wire logic              sysosc_in,
  input wire logic              wdosc_in,
  input wire logic              rtc32k_in,
  input wire logic              sysosc_en,
  input wire logic [WDF_W-1:0]  wdosc_freq,
  input wire logic              pll_pd,
  input wire logic              pll_clk,
  input wire logic              main_clk,
  input wire logic              clock_output_pin,
  input wire logic              watchdog_timer_clk,
  input wire logic              rtc_32k
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence pll_wr_s; ce && wr_stb && addr == PLL_CTRL_ADDR; endsequence
  sequence osc_wr_s; ce && wr_stb && addr == OSC_CTRL_ADDR; endsequence
  sequence pll_rd_s; ce && rd_stb && addr == PLL_CTRL_ADDR; endsequence
  sequence osc_rd_s; ce && rd_stb && addr == OSC_CTRL_ADDR; endsequence
  sequence co_hi_s; ce ##1 clock_output_pin; endsequence
  AST_PD_WR: assert property (pll_wr_s |=> pll_pd == $past(wdata[PLL_PD_BIT]))
    else $error("pll power-down not taken");
  AST_OSC_WR: assert property (osc_wr_s |=> wdosc_freq == $past(wdata[WDF_LSB+:WDF_W]))
    else $error("watchdog frequency code not taken");
  AST_RD_PD: assert property (pll_rd_s |=> rdata[PLL_PD_BIT] == pll_pd)
    else $error("power-down readback wrong");
  AST_RD_OSC: assert property (osc_rd_s |=> rdata[SYSOSC_EN_BIT] == sysosc_en)
    else $error("sysosc enable readback wrong");
  AST_RTC32K: assert property (ce && rst_b |=> rtc_32k == $past(rtc32k_in))
    else $error("32k output not one cycle behind");
  // Pll level may feed the switch before its own register
  AST_MAIN_RISE: assert property ($rose(main_clk) |-> pll_clk || $past(internal_rc_osc | sysosc_in | wdosc_in | rtc32k_in | pll_clk))
    else $error("main clock rose with no source high");
  AST_WDT_SRC: assert property (ce && rst_b |=> watchdog_timer_clk == $past(internal_rc_osc) || watchdog_timer_clk == $past(wdosc_in))
    else $error("watchdog clock from no source");
  AST_CO_SRC: assert property (co_hi_s |-> $past(internal_rc_osc | sysosc_in | wdosc_in | main_clk))
    else $error("clock output high with no source high");
endmodule

bind clk_gen_top clk_gen_properties chk_i (.mclk(mclk), .rst_b(rst_b), .ce(ce), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .internal_rc_osc(internal_rc_osc), .sysosc_in(sysosc_in), .wdosc_in(wdosc_in),
  .rtc32k_in(rtc32k_in), .sysosc_en(sysosc_en), .wdosc_freq(wdosc_freq), .pll_pd(pll_pd),
  .pll_clk(pll_clk), .main_clk(main_clk), .clock_output_pin(clock_output_pin),
  .watchdog_timer_clk(watchdog_timer_clk), .rtc_32k(rtc_32k));

// ---- tb/clk_gen_top_tb_top.sv ----
// Self-checking bench for the clock generation top.
// Assumes oscillator levels may be driven as bits of a free-running count.
`timescale 1ns/10ps
module clk_gen_top_tb_top;
  import clk_gen_pkg::*;
  logic        mclk, rst_b, ce, wr_stb, rd_stb;
  logic        sosc_en, pll_pd, pll_clk, main_clk, co, wdt, r1hz, r1khz, r32k;
  logic [7:0]  addr, cnt;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wdf;
  logic [4:0]  srcv, outv;
  int          miscompares, total_checks, cyc, h, l;
  // Distinct rates so a wrong mux leg shows
  assign srcv = {cnt[3], main_clk, cnt[2:0]};
  assign outv = {r32k, pll_clk, wdt, main_clk, co};
  clk_gen_top #(.PLL_LOCK_CYC(20), .SYSOSC_RDY_CYC(50)) dut (.mclk(mclk), .rst_b(rst_b),
    .ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .internal_rc_osc(cnt[0]), .sysosc_in(cnt[1]), .wdosc_in(cnt[2]), .rtc32k_in(cnt[3]),
    .sysosc_en(sosc_en), .wdosc_freq(wdf), .pll_pd(pll_pd), .pll_clk(pll_clk),
    .main_clk(main_clk), .clock_output_pin(co), .watchdog_timer_clk(wdt),
    .rtc_1hz(r1hz), .rtc_1khz(r1khz), .rtc_32k(r32k));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cnt <= cnt + 8'h01;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
  // Output o must repeat source s one cycle late
  task follow(input int s, input int o);
    logic p;
    @(negedge mclk);
    p = srcv[s];
    repeat (10) begin
      @(negedge mclk);
      chk(32'(outv[o]), 32'(p));
      p = srcv[s];
    end
  endtask
  task halfp(output int n);
    logic v;
    v = pll_clk;
    n = 0;
    while (pll_clk === v && n < 100) begin
      @(negedge mclk);
      n++;
    end
    v = pll_clk;
    n = 0;
    while (pll_clk === v && n < 100) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task t_reset;
    rd(PLL_CTRL_ADDR);
    chk(d, 32'h80);
    chk(32'(pll_pd), 32'h1);
    rd(STATUS_ADDR);
    chk(d, 32'h08);
    follow(0, 1);
    follow(0, 3);
  endtask
  task t_pll;
    for (int p = 0; p < 4; p++) begin
      wr(PLL_CTRL_ADDR, 32'(p * 32 + p * 31 / 3));
      rd(PLL_CTRL_ADDR);
      chk(d, 32'(p * 32 + p * 31 / 3));
      halfp(h);
      halfp(h);
      halfp(l);
      chk(32'(h), 32'(1 << p));
      chk(32'(l), 32'(h));
    end
    wr(PLL_CTRL_ADDR, 32'h0);
    rd(STATUS_ADDR);
    chk(32'(d[0]), 32'h0);
    repeat (25) @(posedge mclk);
    rd(STATUS_ADDR);
    chk(32'(d[0]), 32'h1);
    wr(PLL_CTRL_ADDR, 32'h180);
    follow(1, 3);
  endtask
  task t_sosc;
    wr(OSC_CTRL_ADDR, 32'h01);
    rd(STATUS_ADDR);
    chk(32'(d[1]), 32'h0);
    chk(32'(sosc_en), 32'h1);
    repeat (55) @(posedge mclk);
    rd(STATUS_ADDR);
    chk(32'(d[1]), 32'h1);
  endtask
  // Switch waits for a low source, so poll busy
  task sel_main(input int c);
    int k;
    wr(MAIN_SEL_ADDR, 32'(c));
    k = 0;
    d = 32'h4;
    while (d[2] !== 1'b0 && k < 40) begin
      rd(STATUS_ADDR);
      k++;
    end
    chk(32'(d[7:3]), 32'(1 << c));
  endtask
  task t_main;
    logic q;
    sel_main(2);
    follow(2, 1);
    wr(MAIN_SEL_ADDR, 32'h5);
    rd(MAIN_SEL_ADDR);
    chk(d, 32'h2);
    sel_main(4);
    follow(4, 1);
    sel_main(1);
    follow(1, 1);
    wr(PLL_CTRL_ADDR, 32'h120);
    repeat (25) @(posedge mclk);
    rd(STATUS_ADDR);
    chk(32'(d[0]), 32'h1);
    sel_main(3);
    repeat (10) begin
      @(negedge mclk);
      q = pll_clk;
      @(negedge mclk);
      chk(32'(main_clk), 32'(q));
    end
    sel_main(0);
    follow(0, 1);
  endtask
  task t_misc;
    for (int s = 0; s < 4; s++) begin
      wr(CLOCK_OUTPUT_PIN_ADDR, 32'(4 + s));
      follow(s, 0);
    end
    wr(OSC_CTRL_ADDR, 32'h35);
    follow(2, 2);
    chk(32'(wdf), 32'ha);
    rd(OSC_CTRL_ADDR);
    chk(d, 32'h35);
    wr(OSC_CTRL_ADDR, 32'h01);
    follow(0, 2);
    follow(4, 4);
    h = 0;
    while (r1khz !== 1'b0 && h < 600) begin
      @(negedge mclk);
      h++;
    end
    while (r1khz !== 1'b1 && h < 1200) begin
      @(negedge mclk);
      h++;
    end
    l = 0;
    while (r1khz === 1'b1 && l < 600) begin
      @(negedge mclk);
      l++;
    end
    chk(32'(l), 32'd256);
    rd(8'h14);
    chk(d, 32'h0);
    // The 1 Hz bit needs far more 32k edges than this run makes
    chk(32'(r1hz), 32'h0);
  endtask
  // Clock enable low freezes state and drops strobes
  task t_ce;
    logic q;
    @(posedge mclk);
    ce <= 1'b0;
    wr(CLOCK_OUTPUT_PIN_ADDR, 32'h0);
    q = main_clk;
    repeat (6) begin
      @(negedge mclk);
      chk(32'(main_clk), 32'(q));
    end
    @(posedge mclk);
    ce <= 1'b1;
    rd(CLOCK_OUTPUT_PIN_ADDR);
    chk(d, 32'h7);
  endtask
  task report_and_stop;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {ce, rst_b, wr_stb, rd_stb, addr, wdata, cnt} = '0;
    ce = 1'b1;
    {miscompares, total_checks, cyc} = '0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_pll();
    t_sosc();
    t_main();
    t_misc();
    t_ce();
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    report_and_stop();
  end
endmodule
